/* shared/srw_pkg.sv */
// constants and types for the supervisor reset watchdog
// assumes a single 250 MHz clock and an asynchronous active-high reset
package srw_pkg;
   // -------------------------------------------------------------
   // clock and time figures
   // -------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned STRETCH_MS = 200;
   localparam int unsigned WDOG_TIMEOUT_MS = 1600;
   localparam int unsigned DEBOUNCE_US = 1000; // assumed bounce window
   localparam longint unsigned STRETCH_CYC =
      (64'(STRETCH_MS) * 64'd1000000) / 64'(CLK_PERIOD_NS);
   localparam longint unsigned WDOG_CYC =
      (64'(WDOG_TIMEOUT_MS) * 64'd1000000) / 64'(CLK_PERIOD_NS);
   localparam longint unsigned DEBOUNCE_CYC =
      (64'(DEBOUNCE_US) * 64'd1000) / 64'(CLK_PERIOD_NS);
   // -------------------------------------------------------------
   // widths and reset values
   // -------------------------------------------------------------
   localparam int unsigned CNT_W = 32;
   localparam int unsigned SYNC_W = 5;
   localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0;
   localparam logic [CNT_W-1:0] CNT_ONE = 32'h1;
   // pf resets low to agree with the flag's own reset level
   localparam logic [SYNC_W-1:0] SYNC_RST = 5'h19; // man,kick,low,pf,dis
   localparam int unsigned SI_MAN = 4;
   localparam int unsigned SI_KICK = 3;
   localparam int unsigned SI_LOW = 2;
   localparam int unsigned SI_PF = 1;
   localparam int unsigned SI_DIS = 0;

   typedef enum logic [1:0] {
      SRW_HOLD = 2'b00,
      SRW_STRETCH = 2'b01,
      SRW_RUN = 2'b10
   } srw_rst_state_t;
endpackage

/* hw/srw_sync.sv */
// two-stage synchroniser bank for the supervisor inputs
// assumes inputs may change at any time relative to clk
`timescale 1ns/10ps
module srw_sync
   import srw_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [SYNC_W-1:0] rawIn,
   output logic [SYNC_W-1:0] syncOut
);
   logic [SYNC_W-1:0] meta_ff;
   logic [SYNC_W-1:0] sync_ff;
   logic [SYNC_W-1:0] nxt_meta;
   logic [SYNC_W-1:0] nxt_sync;

   // -------------------------------------------------------------
   // per-bit two flop chain, first stage read only by the second
   // -------------------------------------------------------------
   for (genvar i = 0; i < SYNC_W; i++) begin : g_bit
      always_comb begin
         nxt_meta[i] = rawIn[i];
         nxt_sync[i] = meta_ff[i];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_ff <= SYNC_RST;
         sync_ff <= SYNC_RST;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
      end
   end

   assign syncOut = sync_ff;
endmodule

/* hw/srw_debounce.sv */
// stability filter for the manual reset input
// assumes the input is already synchronised to clk
`timescale 1ns/10ps
module srw_debounce
   import srw_pkg::*;
#(
   parameter logic [CNT_W-1:0] STABLE_CYC = CNT_W'(DEBOUNCE_CYC)
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic levelIn,
   output logic levelOut
);
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;
   logic out_ff;
   logic nxt_out;

   // -------------------------------------------------------------
   // accept a new level only after it stood STABLE_CYC cycles
   // -------------------------------------------------------------
   always_comb begin
      nxt_cnt = CNT_ZERO;
      nxt_out = out_ff;
      if (levelIn != out_ff) begin
         if (cnt_ff >= STABLE_CYC - CNT_ONE) begin
            nxt_out = levelIn;
         end else begin
            nxt_cnt = cnt_ff + CNT_ONE; // bounce restarts the count
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_ff <= CNT_ZERO;
         out_ff <= 1'b1;
      end else begin
         cnt_ff <= nxt_cnt;
         out_ff <= nxt_out;
      end
   end

   assign levelOut = out_ff;
endmodule

/* hw/srw_supervisor.sv */
// supervisor: reset generation, watchdog and power-fail flag
// assumes all inputs asynchronous; one 250 MHz clock; rst is power-on
//
// Operation
// - both reset outputs assert while manual reset input is low
// - manual reset input is debounced against button bounce
// - reset asserts at power-up and whenever supply is low
// - power-fail flag follows comparator: high above threshold
// - expiry output goes low when watchdog counter times out
// - kick edges of either polarity and manual reset clear the watchdog
// - disable indication turns the watchdog off completely
// - reset stays asserted for stretch period after cause ends
// - watchdog timeout never asserts reset directly
// - high reset output is always complement of low reset output
// - after expiry the timeout restarts and repeats until cleared
// - expiry output held low while supply is low
// - expiry output rises at once when supply low clears
// - stretch length is a configurable parameter
`timescale 1ns/10ps
module srw_supervisor
   import srw_pkg::*;
#(
   parameter logic [CNT_W-1:0] STRETCH_LEN = CNT_W'(STRETCH_CYC),
   parameter logic [CNT_W-1:0] WDOG_LEN = CNT_W'(WDOG_CYC),
   parameter logic [CNT_W-1:0] DEBOUNCE_LEN = CNT_W'(DEBOUNCE_CYC),
   parameter logic [CNT_W-1:0] EXPIRY_LEN = CNT_ONE
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic manual_reset_n,
   input wire logic watchdog_kick_in,
   input wire logic watchdogDisable,
   input wire logic supplyLow,
   input wire logic powerfail_sense_in,
   output logic resetOut_n,
   output logic resetOut,
   output logic watchdog_expiry_n,
   output logic powerfail_flag_out
);
   // -------------------------------------------------------------
   // input conditioning
   // -------------------------------------------------------------
   logic [SYNC_W-1:0] syncIn;
   logic manSync;
   logic manClean_n;
   logic kickSync;
   logic lowSync;
   logic pfSync;
   logic disSync;

   // every pin passes two flops before any logic sees it
   srw_sync u_sync (
      .clk(clk),
      .rst(rst),
      .rawIn({manual_reset_n, watchdog_kick_in, supplyLow,
              powerfail_sense_in, watchdogDisable}),
      .syncOut(syncIn)
   );

   // split the synchronised bank back into named levels
   assign manSync = syncIn[SI_MAN];
   assign kickSync = syncIn[SI_KICK];
   assign lowSync = syncIn[SI_LOW];
   assign pfSync = syncIn[SI_PF];
   assign disSync = syncIn[SI_DIS];

   // push-button or logic drive both filtered the same way
   srw_debounce #(
      .STABLE_CYC(DEBOUNCE_LEN)
   ) u_deb (
      .clk(clk),
      .rst(rst),
      .levelIn(manSync),
      .levelOut(manClean_n)
   );

   // -------------------------------------------------------------
   // reset generator
   // -------------------------------------------------------------
   srw_rst_state_t st_ff;
   srw_rst_state_t nxt_st;
   logic [CNT_W-1:0] str_ff;
   logic [CNT_W-1:0] nxt_str;
   logic rstN_ff;
   logic nxt_rstN;
   logic rstH_ff;
   logic nxt_rstH;
   logic cause;

   // any live cause returns to hold; rst itself is power-up
   assign cause = lowSync | ~manClean_n;

   // hold while caused, then count out the stretch
   // a cause that returns mid-stretch restarts the count from zero
   always_comb begin
      nxt_st = st_ff;
      nxt_str = str_ff;
      unique case (st_ff)
         SRW_HOLD: begin
            nxt_str = CNT_ZERO;
            if (!cause) begin
               nxt_st = SRW_STRETCH;
            end
         end
         SRW_STRETCH: begin
            if (cause) begin
               nxt_st = SRW_HOLD;
               nxt_str = CNT_ZERO;
            end else if (str_ff >= STRETCH_LEN - CNT_ONE) begin
               nxt_st = SRW_RUN;
            end else begin
               nxt_str = str_ff + CNT_ONE;
            end
         end
         SRW_RUN: begin
            if (cause) begin
               nxt_st = SRW_HOLD;
            end
         end
         default: begin
            nxt_st = SRW_HOLD;
            nxt_str = CNT_ZERO;
         end
      endcase
      // both outputs from one decision, so never disagree
      nxt_rstN = (nxt_st == SRW_RUN);
      nxt_rstH = (nxt_st != SRW_RUN);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_ff <= SRW_HOLD;
         str_ff <= CNT_ZERO;
         rstN_ff <= 1'b0; // asserted from power-up
         rstH_ff <= 1'b1;
      end else begin
         st_ff <= nxt_st;
         str_ff <= nxt_str;
         rstN_ff <= nxt_rstN;
         rstH_ff <= nxt_rstH;
      end
   end

   // -------------------------------------------------------------
   // watchdog
   // -------------------------------------------------------------
   logic [CNT_W-1:0] wd_ff;
   logic [CNT_W-1:0] nxt_wd;
   logic [CNT_W-1:0] exp_ff;
   logic [CNT_W-1:0] nxt_exp;
   logic kickPrev_ff;
   logic nxt_kickPrev;
   logic expo_ff;
   logic nxt_expo;
   logic kickEdge;

   // edge found on the second sync stage only
   // limitation: kick pulses shorter than one clock may be lost
   assign kickEdge = kickSync ^ kickPrev_ff;

   // expiry shows low for EXPIRY_LEN cycles each period; a level held
   // low would hide the repeat, so the pulse is short by choice
   always_comb begin
      nxt_kickPrev = kickSync;
      nxt_wd = wd_ff;
      nxt_exp = CNT_ZERO;
      if (disSync || kickEdge || !manClean_n) begin
         nxt_wd = CNT_ZERO;
      end else if (wd_ff >= WDOG_LEN - CNT_ONE) begin
         nxt_wd = CNT_ZERO; // restart for the next period
         nxt_exp = EXPIRY_LEN;
      end else begin
         nxt_wd = wd_ff + CNT_ONE;
      end
      if (exp_ff != CNT_ZERO && nxt_exp == CNT_ZERO) begin
         nxt_exp = exp_ff - CNT_ONE;
      end
      if (disSync) begin
         nxt_exp = CNT_ZERO;
      end
      // supply low forces low, release has no delay
      // a level while supply is low, never a counted pulse
      nxt_expo = !(lowSync || nxt_exp != CNT_ZERO);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wd_ff <= CNT_ZERO;
         exp_ff <= CNT_ZERO;
         // match the sync flop, so leaving reset is not a kick edge
         kickPrev_ff <= SYNC_RST[SI_KICK];
         expo_ff <= 1'b1;
      end else begin
         wd_ff <= nxt_wd;
         exp_ff <= nxt_exp;
         kickPrev_ff <= nxt_kickPrev;
         expo_ff <= nxt_expo;
      end
   end

   // -------------------------------------------------------------
   // power-fail flag
   // -------------------------------------------------------------
   logic flag_ff;
   logic nxt_flag;

   // flag follows comparator result, high above threshold
   always_comb begin
      nxt_flag = pfSync;
   end

   // resets low like its sync flop, so no false flag leaves reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flag_ff <= 1'b0;
      end else begin
         flag_ff <= nxt_flag;
      end
   end

   // every pin straight from a flop, so no decode glitch escapes
   assign resetOut_n = rstN_ff;
   assign resetOut = rstH_ff;
   assign watchdog_expiry_n = expo_ff;
   assign powerfail_flag_out = flag_ff;

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   // internal stages are watched, so a failure names the culprit
   sequence s_released;
      !cause ##1 !cause;
   endsequence

   sequence s_no_cause;
      manClean_n && !lowSync;
   endsequence

   AST_COMPL: assert property (@(posedge clk) disable iff (rst)
      resetOut == !resetOut_n)
      else $error("reset outputs not complementary");

   AST_MAN_HOLD: assert property (@(posedge clk) disable iff (rst)
      !manClean_n |=> !resetOut_n)
      else $error("reset not asserted during manual reset");

   AST_LOW_RST: assert property (@(posedge clk) disable iff (rst)
      lowSync |=> resetOut)
      else $error("reset not asserted on low supply");

   AST_STRETCH: assert property (@(posedge clk) disable iff (rst)
      (st_ff == SRW_HOLD) and s_released |-> !resetOut_n)
      else $error("reset released without stretch");

   AST_PF_FLAG: assert property (@(posedge clk) disable iff (rst)
      pfSync |=> powerfail_flag_out)
      else $error("power-fail flag not following comparator");

   AST_PF_LOW: assert property (@(posedge clk) disable iff (rst)
      !pfSync |=> !powerfail_flag_out)
      else $error("power-fail flag high with comparator low");

   AST_EXP_LOW: assert property (@(posedge clk) disable iff (rst)
      lowSync |=> !watchdog_expiry_n)
      else $error("expiry output high while supply low");

   AST_EXP_REL: assert property (@(posedge clk) disable iff (rst)
      $fell(lowSync) && nxt_exp == CNT_ZERO |=> watchdog_expiry_n)
      else $error("expiry output delayed after supply recovery");

   AST_KICK_CLR: assert property (@(posedge clk) disable iff (rst)
      kickEdge |=> wd_ff == CNT_ZERO)
      else $error("kick edge did not clear watchdog");

   AST_MAN_CLR: assert property (@(posedge clk) disable iff (rst)
      !manClean_n |=> wd_ff == CNT_ZERO)
      else $error("manual reset did not clear watchdog");

   AST_EXPIRE: assert property (@(posedge clk) disable iff (rst)
      !disSync && !kickEdge && manClean_n && !lowSync
      && wd_ff == WDOG_LEN - CNT_ONE |=> !watchdog_expiry_n
      ##0 wd_ff == CNT_ZERO)
      else $error("watchdog timeout missed");

   AST_DIS: assert property (@(posedge clk) disable iff (rst)
      disSync |=> wd_ff == CNT_ZERO)
      else $error("watchdog counted while disabled");

   AST_DIS_QUIET: assert property (@(posedge clk) disable iff (rst)
      disSync && !lowSync |=> watchdog_expiry_n)
      else $error("expiry indicated while watchdog disabled");

   AST_NO_WD_RST: assert property (@(posedge clk) disable iff (rst)
      (st_ff == SRW_RUN) and s_no_cause |=> resetOut_n)
      else $error("reset asserted without a cause");

   AST_STR_FULL: assert property (@(posedge clk) disable iff (rst)
      $rose(resetOut_n) |-> str_ff == STRETCH_LEN - CNT_ONE)
      else $error("reset released before stretch ended");
endmodule

/* test/srw_cpu_model.sv */
// processor model that services the supervisor watchdog
// assumes it shares clk with the supervisor and sees its low reset
`timescale 1ns/10ps
module srw_cpu_model #(
   parameter int KICK_GAP = 30
) (
   input wire logic clk,
   input wire logic resetOut_n,
   input wire logic kickEn,
   output logic kickOut
);
   // ------------------------------------------------------------
   // kick generator
   // ------------------------------------------------------------
   int gapCnt;

   initial begin
      kickOut = 1'b0;
      gapCnt = 0;
   end

   // a processor held in reset cannot service the timer, so no kicks
   always @(posedge clk) begin
      if (!kickEn || resetOut_n !== 1'b1) begin
         gapCnt <= 0;
      end else if (gapCnt == KICK_GAP - 1) begin
         gapCnt <= 0;
         kickOut <= #1 ~kickOut;
      end else begin
         gapCnt <= gapCnt + 1;
      end
   end
endmodule

/* test/test_supervisor_reset_watchdog.sv */
// self-checking bench for the supervisor reset watchdog
// assumes short counts set below; the processor model kicks the timer
`timescale 1ns/10ps
`define CHK(got, exp, msg) begin checks++; if ((got) !== (exp)) begin \
   n_fail++; $display("ERROR %0t %s", $time, msg); end end
module test_supervisor_reset_watchdog;
   import srw_pkg::*;
   // ------------------------------------------------------------
   // settings, signals and instances
   // ------------------------------------------------------------
   localparam int STR = 20;
   localparam int WDG = 50;
   localparam int DEB = 4;
   logic clk, rst, mnN, wdDis, supLow, pfIn, kickEn, kick;
   logic resetOut_n, resetOut, expN, pfOut;
   int n_fail, checks, cycCnt, expLow, rstLow, n;

   srw_supervisor #(
      .STRETCH_LEN(CNT_W'(STR)),
      .WDOG_LEN(CNT_W'(WDG)),
      .DEBOUNCE_LEN(CNT_W'(DEB)),
      .EXPIRY_LEN(CNT_ONE)
   ) dut (
      .clk(clk),
      .rst(rst),
      .manual_reset_n(mnN),
      .watchdog_kick_in(kick),
      .watchdogDisable(wdDis),
      .supplyLow(supLow),
      .powerfail_sense_in(pfIn),
      .resetOut_n(resetOut_n),
      .resetOut(resetOut),
      .watchdog_expiry_n(expN),
      .powerfail_flag_out(pfOut)
   );

   srw_cpu_model #(.KICK_GAP(30)) cpu (
      .clk(clk),
      .resetOut_n(resetOut_n),
      .kickEn(kickEn),
      .kickOut(kick)
   );

   always #2 clk = ~clk;

   // ------------------------------------------------------------
   // monitors and timeout
   // ------------------------------------------------------------
   // pulses are one cycle wide, so count them at every edge
   always @(posedge clk) begin
      cycCnt++;
      if (expN === 1'b0) expLow++;
      if (resetOut_n === 1'b0) rstLow++;
      if (!rst) `CHK(resetOut, ~resetOut_n, "reset pair mismatch")
      if (cycCnt == 4000) begin
         n_fail++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic step(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   // bounded wait for reset release, returns cycles waited
   task automatic waitRel(output int c);
      c = 0;
      while (resetOut_n !== 1'b1 && c < 200) begin
         step(1);
         c++;
      end
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic tPowerUp();
      `CHK(resetOut_n, 1'b0, "no reset at power-up")
      rst = 1'b0;
      waitRel(n);
      `CHK(n >= STR && n <= STR + 8, 1'b1, "power-up stretch")
   endtask

   task automatic tPowerFail();
      pfIn = 1'b1;
      step(4);
      `CHK(pfOut, 1'b1, "flag not high")
      pfIn = 1'b0;
      step(4);
      `CHK(pfOut, 1'b0, "flag not low")
   endtask

   // both kick edges must clear: one edge every 30 is under 50 only
   task automatic tKick();
      step(40);
      expLow = 0;
      step(200);
      `CHK(expLow, 0, "expiry despite kicks")
   endtask

   task automatic tExpiry();
      kickEn = 1'b0;
      rstLow = 0;
      n = 0;
      while (expN !== 1'b0 && n < 120) begin
         step(1);
         n++;
      end
      `CHK(n < 120, 1'b1, "no expiry")
      step(2);
      expLow = 0;
      step(123);
      `CHK(expLow, 2, "expiry not repeated")
      `CHK(rstLow, 0, "timeout drove reset")
   endtask

   task automatic tDisable();
      wdDis = 1'b1;
      step(4);
      expLow = 0;
      step(200);
      `CHK(expLow, 0, "expiry while disabled")
      wdDis = 1'b0;
      kickEn = 1'b1;
      step(40);
   endtask

   task automatic tSupply();
      supLow = 1'b1;
      step(4);
      `CHK(resetOut_n, 1'b0, "no reset on low supply")
      step(60);
      `CHK(expN, 1'b0, "expiry not held low")
      supLow = 1'b0;
      step(4);
      `CHK(expN, 1'b1, "expiry not released")
      `CHK(resetOut_n, 1'b0, "reset not stretched")
      waitRel(n);
      `CHK(n >= STR - 4 && n <= STR + 6, 1'b1, "supply stretch")
   endtask

   task automatic tManual();
      rstLow = 0;
      mnN = 1'b0;
      step(2);
      mnN = 1'b1;
      step(12);
      `CHK(rstLow, 0, "bounce gave reset")
      mnN = 1'b0;
      step(12);
      `CHK(resetOut_n, 1'b0, "manual reset missing")
      mnN = 1'b1;
      waitRel(n);
      `CHK(n >= STR && n <= STR + DEB + 8, 1'b1, "manual stretch")
   endtask

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      mnN = 1'b1;
      wdDis = 1'b0;
      supLow = 1'b0;
      pfIn = 1'b0;
      kickEn = 1'b1;
      n_fail = 0;
      checks = 0;
      cycCnt = 0;
      expLow = 0;
      rstLow = 0;
      step(10);
      tPowerUp();
      tPowerFail();
      tKick();
      tExpiry();
      tDisable();
      tSupply();
      tManual();
      end_sim();
   end
endmodule
